// [rtl/sar_ctrl.sv]
// Converter control: registers, triggers, clocking, routing
// Notes on behaviour
// - Clock gate set at reset; clear stops converter
// - Reserved codes still convert, result undefined
// - Five-bit code picks pins and internal sources
// - Four selectable conversion clock sources
// - External reference clock feeds alternate clock
// - Hardware trigger starts on each match while idle
// - Match triggers regardless of match interrupt
// - Trigger works in every listed power mode
// - Twelve-bit linear successive approximation search
// - Result twelve, ten or eight bits, right-justified
// - Single or continuous; single returns idle
// - Optional compare, less or greater-equal
// - Done flag with optional interrupt
// - Converter keeps working in wait and stop3
// - Control write aborts, restarts unless trigger mode set
// - All-ones code turns off, no extra conversion
// - Done flag cleared by write or low read
// - With compare, flag set only when true
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl
	import sar_ctrl_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  wire logic [3:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	input  wire logic                 local_async_conv_clock,
	input  wire logic                 clock_source_ext_ref_clock,
	input  wire logic                 time_of_day_match,
	input  wire logic                 cmp_hi,
	output logic [SAR_RES_W-1:0]      dac_code,
	output sar_mux_t                  mux_sel,
	output logic [7:0]                pin_analog_en,
	output logic                      conv_clock_on,
	output logic                      conv_active,
	output logic                      conv_irq
);
	////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]           sc1_r;        // Done, enable, continuous, code
	logic [7:0]           sc2_r;        // Trigger and compare control
	logic [7:0]           cfg_r;        // Width mode and clock source
	logic [7:0]           gate_r;       // Peripheral clock gate
	logic [7:0]           pin_r;        // Pin analog control
	logic [SAR_RES_W-1:0] cmpv_r;       // Compare value
	logic [SAR_RES_W-1:0] res_r;        // Formatted result
	logic [7:0]           rdata_r;      // Read data
	logic                 irq_r;        // Interrupt output
	logic                 act_r;        // Active output
	logic                 ckon_r;       // Clock gate output
	logic [SAR_RES_W-1:0] dac_r;        // DAC code output
	sar_mux_t             mux_r;        // Routing output
	logic [7:0]           pinen_r;      // Pin enable output
	logic                 half_r;       // Bus clock divided by two
	logic                 async_d_r;    // Async clock history
	logic                 alt_d_r;      // Alternate clock history
	logic                 alternate_conv_clock;
	logic                 step;         // Conversion clock tick
	logic                 wr_sc1;       // Control one written
	logic                 rd_low;       // Result low read
	logic                 sel_off;      // Module turned off
	logic                 sw_start;     // Software start
	logic                 hw_start;     // Hardware start
	logic                 cont_start;   // Continuous restart
	logic                 eng_start;    // Engine start
	logic                 eng_busy;     // Engine running
	logic                 eng_done;     // Engine finished
	logic [SAR_RES_W-1:0] eng_code;     // Engine trial code
	logic [SAR_RES_W-1:0] eng_res;      // Engine raw result
	logic [SAR_RES_W-1:0] fmt;          // Width-formatted result
	logic                 cmp_ok;       // Compare outcome
	logic                 done_set;     // Flag set event
	logic                 done_nxt;     // Next flag value
	logic [SAR_NPINS-1:0] pin_hit;      // Pin decode

	assign reg_rdata     = rdata_r;
	assign conv_irq      = irq_r;
	assign conv_active   = act_r;
	assign conv_clock_on = ckon_r;
	assign dac_code      = dac_r;
	assign mux_sel       = mux_r;
	assign pin_analog_en = pinen_r;

	////////////////////////////////////////////////////////////////
	// Bus decode
	// Only the offsets with side effects are decoded here; plain
	// registers decode their own offset where they are written
	assign wr_sc1  = reg_wr && (reg_addr == SAR_A_SC1);
	assign rd_low  = reg_rd && (reg_addr == SAR_A_RL);
	assign sel_off = (sc1_r[4:0] == SAR_SEL_OFF);

	// Alternate clock is the external reference clock
	assign alternate_conv_clock = clock_source_ext_ref_clock;

	////////////////////////////////////////////////////////////////
	// Conversion clock tick selection, never gated by power mode
	// A slow source gives one tick per rising edge, seen a bus cycle late;
	// it must stay below half the bus clock or edges are lost
	always_comb begin
		unique case (cfg_r[1:0])
			SAR_CK_BUS:   step = 1'b1;
			SAR_CK_BUS2:  step = half_r;
			SAR_CK_ASYNC: step = local_async_conv_clock & ~async_d_r;
			SAR_CK_ALT:   step = alternate_conv_clock & ~alt_d_r;
		endcase
		// Gate bit stops the converter clock
		if (!gate_r[SAR_GATE_BIT]) step = 1'b0;
	end

	// Edge history for the slow clock sources
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			half_r    <= 1'b0;
			async_d_r <= 1'b0;
			alt_d_r   <= 1'b0;
		end else begin
			half_r    <= ~half_r;
			async_d_r <= local_async_conv_clock;
			alt_d_r   <= alternate_conv_clock;
		end
	end

	////////////////////////////////////////////////////////////////
	// Start and abort
	// Software start is blocked in trigger mode so that a stray write
	// cannot start a conversion that belongs to the match event.
	// A write in the same cycle as a match or completion wins: it aborts,
	// and the only restart is the write's own
	// Write to control one restarts unless code is all ones or trigger mode is set
	assign sw_start = wr_sc1 && (reg_wdata[4:0] != SAR_SEL_OFF) &&
		!sc2_r[SAR_SC2_HWT];
	// Every match while idle starts a conversion, no interrupt needed
	assign hw_start = sc2_r[SAR_SC2_HWT] && time_of_day_match &&
		!sel_off && !eng_busy && !wr_sc1;
	// Continuous restarts; off code ends it
	assign cont_start = eng_done && sc1_r[SAR_SC1_CONT] &&
		!sel_off && !wr_sc1;
	assign eng_start = sw_start | hw_start | cont_start;

	// Abort is every control one write; start overrides it inside the
	// engine, so a restarting write costs no idle cycle
	// Reserved codes convert like any other
	sar_engine u_engine (
		.clock  (clock),
		.resetn (resetn),
		.start  (eng_start),
		.abort  (wr_sc1),
		.step   (step),
		.cmp_hi (cmp_hi),
		.busy   (eng_busy),
		.done   (eng_done),
		.code   (eng_code),
		.result (eng_res)
	);

	////////////////////////////////////////////////////////////////
	// Result formatting and compare
	// Narrow widths drop low bits so the result stays right-justified;
	// mode three falls to the default and reads as eight bits
	always_comb begin
		unique case (cfg_r[3:2])
			SAR_MODE12: fmt = eng_res;
			SAR_MODE10: fmt = eng_res >> SAR_SH10;
			default:    fmt = eng_res >> SAR_SH8;
		endcase
	end

	// Compare runs on the formatted result, so software must
	// program the value in the width of the selected mode
	// Less than or greater-or-equal compare
	assign cmp_ok = !sc2_r[SAR_SC2_CMPE] ||
		(sc2_r[SAR_SC2_CMPG] ? (fmt >= cmpv_r) : (fmt < cmpv_r));
	// Flag only on true compare
	assign done_set = eng_done && cmp_ok;
	// Set wins over clear
	assign done_nxt = done_set ? 1'b1 :
		((wr_sc1 || rd_low) ? 1'b0 : sc1_r[SAR_SC1_DONE]);

	////////////////////////////////////////////////////////////////
	// Control one
	// Flag bit follows done_nxt only, which keeps it read-only
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sc1_r <= SAR_SC1_RST;
		end else begin
			if (wr_sc1) begin
				sc1_r[6:0] <= reg_wdata[6:0];
			end
			sc1_r[SAR_SC1_DONE] <= done_nxt;
		end
	end

	// Control two, active bit follows the engine
	// Active bit lags the engine one cycle, as the active output does
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sc2_r <= SAR_SC2_RST;
		end else begin
			if (reg_wr && (reg_addr == SAR_A_SC2)) begin
				sc2_r[6:0] <= reg_wdata[6:0];
			end
			sc2_r[SAR_SC2_ACT] <= eng_busy;
		end
	end

	// Configuration, gate, pin control, compare value
	// A zero gate freezes the ticks: a running conversion stalls and
	// carries on from the same bit when the gate is set again
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg_r  <= SAR_CFG_RST;
			gate_r <= SAR_GATE_RST;
			pin_r  <= SAR_ZERO8;
			cmpv_r <= '0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				SAR_A_CFG:  cfg_r  <= reg_wdata;
				SAR_A_GATE: gate_r <= reg_wdata;
				SAR_A_PIN:  pin_r  <= reg_wdata;
				SAR_A_CVH:  cmpv_r[11:8] <= reg_wdata[3:0];
				SAR_A_CVL:  cmpv_r[7:0]  <= reg_wdata;
				default: begin
					// Other offsets ignored here
				end
			endcase
		end
	end

	// Result captured with the flag
	// A compare miss keeps the previous result
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			res_r <= '0;
		end else if (done_set) begin
			res_r <= fmt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data, valid one cycle after the strobe
	// Outside the answer cycle the data return to zero, so a late
	// sample never shows stale register contents
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= SAR_ZERO8;
		end else if (reg_rd) begin
			unique case (reg_addr)
				SAR_A_SC1:  rdata_r <= sc1_r;
				SAR_A_SC2:  rdata_r <= sc2_r;
				SAR_A_RH:   rdata_r <= {4'h0, res_r[11:8]};
				SAR_A_RL:   rdata_r <= res_r[7:0];
				SAR_A_CVH:  rdata_r <= {4'h0, cmpv_r[11:8]};
				SAR_A_CVL:  rdata_r <= cmpv_r[7:0];
				SAR_A_CFG:  rdata_r <= cfg_r;
				SAR_A_GATE: rdata_r <= gate_r;
				SAR_A_PIN:  rdata_r <= pin_r;
				default:    rdata_r <= SAR_ZERO8;
			endcase
		end else begin
			rdata_r <= SAR_ZERO8;
		end
	end

	////////////////////////////////////////////////////////////////
	// Input routing decode
	// Reserved codes hit no route but still power the converter
	for (genvar i = 0; i < SAR_NPINS; i++) begin : g_pin
		assign pin_hit[i] = (sc1_r[4:0] == 5'(i));
	end

	// Registered routing and status outputs
	// Every output is a flop; the DAC copy takes the engine's next code
	// so that it equals the code under trial at each step edge
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mux_r   <= '0;
			pinen_r <= SAR_ZERO8;
			irq_r   <= 1'b0;
			act_r   <= 1'b0;
			ckon_r  <= 1'b0;
			dac_r   <= '0;
		end else begin
			mux_r.pin        <= pin_hit;
			mux_r.lcd_supply <= (sc1_r[4:0] == SAR_SEL_LCD);
			mux_r.lcd_level  <= (sc1_r[4:0] == SAR_SEL_VLL);
			mux_r.temp       <= (sc1_r[4:0] == SAR_SEL_TEMP);
			mux_r.bandgap    <= (sc1_r[4:0] == SAR_SEL_BGAP);
			mux_r.powered    <= !sel_off;
			pinen_r <= pin_r;
			// Interrupt from the flag
			irq_r  <= done_nxt && sc1_r[SAR_SC1_AIEN];
			act_r  <= eng_busy;
			ckon_r <= gate_r[SAR_GATE_BIT];
			dac_r  <= eng_code;
		end
	end
endmodule : sar_ctrl
`default_nettype wire

// [rtl/sar_ctrl_pkg.sv]
// Shared constants and types for the converter control block
package sar_ctrl_pkg;
	localparam int          SAR_RES_W   = 12;        // Converter resolution
	localparam logic [3:0]  SAR_BIT_MSB = 4'hB;      // Top bit index of the search
	localparam logic [11:0] SAR_CODE_MSB = 12'h800;  // First trial code
	// Register map
	localparam logic [3:0]  SAR_A_SC1  = 4'h0;       // Status and control one
	localparam logic [3:0]  SAR_A_SC2  = 4'h1;       // Status and control two
	localparam logic [3:0]  SAR_A_RH   = 4'h2;       // Result high byte
	localparam logic [3:0]  SAR_A_RL   = 4'h3;       // Result low byte
	localparam logic [3:0]  SAR_A_CVH  = 4'h4;       // Compare value high
	localparam logic [3:0]  SAR_A_CVL  = 4'h5;       // Compare value low
	localparam logic [3:0]  SAR_A_CFG  = 4'h6;       // Configuration
	localparam logic [3:0]  SAR_A_GATE = 4'h7;       // Clock gate register
	localparam logic [3:0]  SAR_A_PIN  = 4'h8;       // Pin analog control
	// Field positions
	localparam int SAR_SC1_DONE = 7;                 // Conversion done flag
	localparam int SAR_SC1_AIEN = 6;                 // Done interrupt enable
	localparam int SAR_SC1_CONT = 5;                 // Continuous mode
	localparam int SAR_SC2_ACT  = 7;                 // Conversion active
	localparam int SAR_SC2_HWT  = 6;                 // Hardware trigger select
	localparam int SAR_SC2_CMPE = 5;                 // Compare enable
	localparam int SAR_SC2_CMPG = 4;                 // Compare greater-or-equal
	localparam int SAR_GATE_BIT = 0;                 // Converter clock gate
	// Reset values
	localparam logic [7:0] SAR_SC1_RST  = 8'h1F;     // Module off
	localparam logic [7:0] SAR_SC2_RST  = 8'h00;
	localparam logic [7:0] SAR_CFG_RST  = 8'h00;
	localparam logic [7:0] SAR_GATE_RST = 8'h01;     // Clock on after reset
	localparam logic [7:0] SAR_ZERO8    = 8'h00;
	// Input selection codes
	localparam logic [4:0] SAR_SEL_OFF  = 5'h1F;
	localparam logic [4:0] SAR_SEL_LCD  = 5'h14;
	localparam logic [4:0] SAR_SEL_VLL  = 5'h15;
	localparam logic [4:0] SAR_SEL_TEMP = 5'h1A;
	localparam logic [4:0] SAR_SEL_BGAP = 5'h1B;
	localparam int         SAR_NPINS    = 8;
	// Result width modes
	localparam logic [1:0] SAR_MODE8  = 2'h0;
	localparam logic [1:0] SAR_MODE12 = 2'h1;
	localparam logic [1:0] SAR_MODE10 = 2'h2;
	localparam int         SAR_SH10   = 2;
	localparam int         SAR_SH8    = 4;
	// Conversion clock sources
	localparam logic [1:0] SAR_CK_BUS   = 2'h0;
	localparam logic [1:0] SAR_CK_BUS2  = 2'h1;
	localparam logic [1:0] SAR_CK_ASYNC = 2'h2;
	localparam logic [1:0] SAR_CK_ALT   = 2'h3;

	// Analog input routing
	typedef struct packed {
		logic [SAR_NPINS-1:0] pin;        // Port pin inputs
		logic                 lcd_supply; // Display supply level
		logic                 lcd_level;  // Display level one
		logic                 temp;       // Temperature sensor
		logic                 bandgap;    // Bandgap reference
		logic                 powered;    // Converter powered
	} sar_mux_t;

	typedef enum logic [2:0] {
		SAR_IDLE   = 3'b001,
		SAR_SAMPLE = 3'b010,
		SAR_STEP   = 3'b100
	} sar_state_t;
endpackage : sar_ctrl_pkg

// [rtl/sar_engine.sv]
// Successive-approximation search engine
`timescale 1ns/1ps
`default_nettype none
module sar_engine
	import sar_ctrl_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  wire logic                 start,
	input  wire logic                 abort,
	input  wire logic                 step,
	input  wire logic                 cmp_hi,
	output logic                      busy,
	output logic                      done,
	output logic [SAR_RES_W-1:0]      code,
	output logic [SAR_RES_W-1:0]      result
);
	sar_state_t           state_r;   // Search state
	logic [3:0]           bit_r;     // Bit under trial
	logic [SAR_RES_W-1:0] code_r;    // Trial code to the DAC
	logic                 done_r;    // Completion pulse
	logic [SAR_RES_W-1:0] result_r;  // Final code
	logic [SAR_RES_W-1:0] code_nxt;  // Trial code after this edge

	// Code leaves ahead of the register so an outside flop copy equals code_r
	assign busy   = (state_r != SAR_IDLE);
	assign done   = done_r;
	assign code   = code_nxt;
	assign result = result_r;

	////////////////////////////////////////////////////////////////
	// Next trial code: drop the bit on a low compare, try the next one
	always_comb begin
		code_nxt = code_r;
		if (start) begin
			code_nxt = SAR_CODE_MSB;
		end else if (!abort && step && (state_r == SAR_STEP)) begin
			if (!cmp_hi) code_nxt[bit_r] = 1'b0;
			if (bit_r != 4'h0) code_nxt[bit_r - 4'h1] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Search sequence, start wins over abort
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r  <= SAR_IDLE;
			bit_r    <= SAR_BIT_MSB;
			code_r   <= '0;
			done_r   <= 1'b0;
			result_r <= '0;
		end else begin
			done_r <= 1'b0;
			code_r <= code_nxt;
			if (start) begin
				// Fresh conversion
				state_r <= SAR_SAMPLE;
				bit_r   <= SAR_BIT_MSB;
			end else if (abort) begin
				state_r <= SAR_IDLE;
			end else if (step) begin
				unique case (state_r)
					SAR_IDLE: begin
						state_r <= SAR_IDLE;
					end
					SAR_SAMPLE: begin
						state_r <= SAR_STEP;
					end
					SAR_STEP: begin
						// Last bit decided: the next code is the answer
						if (bit_r == 4'h0) begin
							state_r  <= SAR_IDLE;
							done_r   <= 1'b1;
							result_r <= code_nxt;
						end else begin
							bit_r <= bit_r - 4'h1;
						end
					end
				endcase
			end
		end
	end
endmodule : sar_engine
`default_nettype wire

// [test/sar_ctrl_analog.sv]
// Analog side: comparator against the trial code
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_analog
	import sar_ctrl_pkg::*;
(
	input wire logic        clock,
	input wire sar_mux_t    mux_sel,
	input wire logic [11:0] dac_code,
	input wire logic [11:0] level,
	output logic            cmp_hi
);
	logic junk_r = 1'b0; // Changing value when unpowered
	// Meaningless output while the converter is off
	always @(posedge clock) junk_r <= ~junk_r;
	// Comparator: input at or above trial code
	always_comb cmp_hi = mux_sel.powered ? (level >= dac_code) : junk_r;
endmodule : sar_ctrl_analog
`default_nettype wire

// [test/sar_ctrl_bench.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_bench
	import sar_ctrl_pkg::*;
;
	logic        clock = 1'b0;            // Bus clock
	logic        resetn = 1'b0;           // Async reset
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        async_ck = 1'b0;         // Local async clock
	logic        ref_ck = 1'b0;           // External reference clock
	logic        time_of_day_counter = 1'b0;              // Match pulse
	logic        cmp_hi;
	logic [11:0] dac_code;
	sar_mux_t    mux_sel;
	logic [7:0]  pin_en;
	logic        clk_on;
	logic        active;
	logic        irq;
	logic [11:0] level = 12'h000;         // Analog input level
	logic [31:0] seed = 32'h000138B5;     // Starts at 80053
	logic [8:0]  exp_q[$];                // Notes {check, value}
	logic [8:0]  note;
	logic        rd_seen = 1'b0;
	int          miscompares = 0;
	int          compares = 0;
	int          cycles = 0;
	logic [7:0]  rst_tab [10] = '{8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	logic [4:0]  codes [8] = '{5'h00, 5'h03, 5'h07, 5'h14, 5'h15, 5'h1A, 5'h1B, 5'h08};
	sar_ctrl u_sar_ctrl (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_async_conv_clock(async_ck),
		.clock_source_ext_ref_clock(ref_ck), .time_of_day_match(time_of_day_counter), .cmp_hi(cmp_hi),
		.dac_code(dac_code), .mux_sel(mux_sel), .pin_analog_en(pin_en), .conv_clock_on(clk_on),
		.conv_active(active), .conv_irq(irq));
	sar_ctrl_analog u_sar_ctrl_analog (.clock(clock), .mux_sel(mux_sel), .dac_code(dac_code),
		.level(level), .cmp_hi(cmp_hi));
	////////////////////////////////////////////////////////////////
	always #25 clock = ~clock;
	// Slow clocks and the hang limit
	always @(posedge clock) begin
		cycles <= cycles + 1;
		async_ck <= cycles[1];
		ref_ck <= cycles[2];
		if (cycles == 40000) begin
			miscompares = miscompares + 1;
			test_done();
		end
	end
	// Read results against the oldest note
	always @(posedge clock) rd_seen <= reg_rd;
	always @(negedge clock) begin
		if (rd_seen && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note[8]) check(reg_rdata, note[7:0]);
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Expected routing for a selection code
	function automatic sar_mux_t mux_exp(input logic [4:0] c);
		sar_mux_t m;
		m = '0;
		if (c < 5'h08) m.pin[c[2:0]] = 1'b1;
		m.lcd_supply = c == SAR_SEL_LCD;
		m.lcd_level = c == SAR_SEL_VLL;
		m.temp = c == SAR_SEL_TEMP;
		m.bandgap = c == SAR_SEL_BGAP;
		m.powered = c != SAR_SEL_OFF;
		return m;
	endfunction : mux_exp
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic v, input logic [7:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back({v, e});
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask : rd
	// Poll until done; leaves last status on the read port
	task automatic wait_done(input int lim);
		for (int i = 0; i < lim; i++) begin
			rd(SAR_A_SC1, 1'b0, 8'h00);
			@(negedge clock);
			if (reg_rdata[SAR_SC1_DONE] === 1'b1) break;
		end
	endtask : wait_done
	// One conversion at a random level, formatted result read back
	task automatic conv(input logic [7:0] cfg);
		logic [11:0] e;
		repeat (12) seed = lfsr(seed);
		e = seed[11:0];
		level <= e;
		e = cfg[3:2] == SAR_MODE8 ? e >> SAR_SH8 : cfg[3:2] == SAR_MODE12 ? e : e >> SAR_SH10;
		wr(SAR_A_CFG, cfg);
		wr(SAR_A_SC1, 8'h00);
		wait_done(100);
		check(reg_rdata[SAR_SC1_DONE], 1'b1);
		rd(SAR_A_RH, 1'b1, {4'h0, e[11:8]});
		rd(SAR_A_RL, 1'b1, e[7:0]);
		rd(SAR_A_SC1, 1'b1, 8'h00);
	endtask : conv
	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		// Reset values, one unmapped offset, clock gate
		for (int i = 0; i < 10; i++) rd(i[3:0], 1'b1, rst_tab[i]);
		check(clk_on, 1'b1);
		wr(SAR_A_GATE, 8'h00);
		@(posedge clock);
		@(negedge clock);
		check(clk_on, 1'b0);
		wr(SAR_A_GATE, 8'h01);
		wr(SAR_A_PIN, 8'hA5);
		rd(SAR_A_PIN, 1'b1, 8'hA5);
		check(pin_en, 8'hA5);
		$display("test reset done");
		// Width modes, then all clock sources; async clock only in run mode here
		for (int m = 0; m < 3; m++) conv({4'h0, m[1:0], 2'h0});
		for (int k = 0; k < 4; k++) conv({6'h01, k[1:0]});
		$display("test widths and clocks done");
		// Routing; bandgap buffer taken as on, run mode only
		foreach (codes[i]) begin
			wr(SAR_A_SC1, {3'h0, codes[i]});
			@(posedge clock);
			@(negedge clock);
			check(mux_sel, mux_exp(codes[i]));
		end
		wait_done(100);
		check(reg_rdata[SAR_SC1_DONE], 1'b1);
		$display("test routing done");
		// Continuous, then off code
		wr(SAR_A_SC1, 8'h20);
		wait_done(100);
		check(reg_rdata[SAR_SC1_DONE], 1'b1);
		rd(SAR_A_RL, 1'b0, 8'h00);
		wait_done(100);
		check(reg_rdata[SAR_SC1_DONE], 1'b1);
		wr(SAR_A_SC1, 8'h3F);
		repeat (40) @(posedge clock);
		rd(SAR_A_SC1, 1'b1, 8'h3F);
		$display("test continuous done");
		// Abort mid-run, restart with interrupt
		wr(SAR_A_SC1, 8'h00);
		repeat (5) @(posedge clock);
		wr(SAR_A_SC1, 8'h40);
		wait_done(100);
		check(irq, 1'b1);
		rd(SAR_A_RL, 1'b0, 8'h00);
		@(posedge clock);
		@(negedge clock);
		check(irq, 1'b0);
		$display("test abort done");
		// Compare at the boundary, both senses
		level <= 12'h400;
		wr(SAR_A_CFG, 8'h04);
		for (int i = 0; i < 4; i++) begin
			wr(SAR_A_SC2, i[1] ? 8'h30 : 8'h20);
			wr(SAR_A_CVH, 8'h04);
			wr(SAR_A_CVL, {7'h00, i[0] ^ i[1]});
			wr(SAR_A_SC1, 8'h40);
			wait_done(40);
			check(reg_rdata[SAR_SC1_DONE], i[0]);
			check(irq, i[0]);
		end
		$display("test compare done");
		// Hardware trigger on every match, write alone does not start
		wr(SAR_A_SC2, 8'h40);
		wr(SAR_A_SC1, 8'h00);
		repeat (30) @(posedge clock);
		rd(SAR_A_SC1, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			time_of_day_counter <= 1'b1;
			@(posedge clock);
			time_of_day_counter <= 1'b0;
			wait_done(100);
			check(reg_rdata[SAR_SC1_DONE], 1'b1);
			rd(SAR_A_RL, 1'b0, 8'h00);
		end
		$display("test trigger done");
		repeat (4) @(posedge clock);
		test_done();
	end
endmodule : sar_ctrl_bench
bind sar_ctrl sar_ctrl_checker u_sar_ctrl_checker (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .mux_sel(mux_sel), .conv_clock_on(conv_clock_on),
	.conv_active(conv_active), .conv_irq(conv_irq));
`default_nettype wire

// [test/sar_ctrl_checker.sv]
// Port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_checker
	import sar_ctrl_pkg::*;
(
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire sar_mux_t   mux_sel,
	input wire logic       conv_clock_on,
	input wire logic       conv_active,
	input wire logic       conv_irq
);
	logic sc1_wr;  // Control one written
	logic sc1_go;  // Software start
	logic hwt_r;   // Shadow of trigger select
	logic cont_r;  // Shadow of continuous bit
	logic aien_r;  // Shadow of done interrupt enable
	assign sc1_wr = reg_wr && reg_addr == SAR_A_SC1;
	assign sc1_go = sc1_wr && reg_wdata[4:0] != SAR_SEL_OFF && !hwt_r;
	////////////////////////////////////////////////////////////////
	// Shadow of control two
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hwt_r <= 1'b0;
		end else if (reg_wr && reg_addr == SAR_A_SC2) begin
			hwt_r <= reg_wdata[SAR_SC2_HWT];
		end
	end
	// Shadow of control one
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cont_r <= 1'b0;
			aien_r <= 1'b0;
		end else if (sc1_wr) begin
			cont_r <= reg_wdata[SAR_SC1_CONT];
			aien_r <= reg_wdata[SAR_SC1_AIEN];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Interrupt quiet for 13 cycles, the whole conversion at the bus clock
	sequence irq_quiet;
		!conv_irq [*8] ##1 !conv_irq [*5];
	endsequence
	sequence gate_wr;
		reg_wr && reg_addr == SAR_A_GATE;
	endsequence
	chk_gate_reset: assert property ($rose(resetn) |=> conv_clock_on)
		else $error("clock gate not on after reset");
	chk_gate_write: assert property (gate_wr |-> ##2 conv_clock_on == $past(reg_wdata[SAR_GATE_BIT], 2))
		else $error("clock gate does not follow write");
	chk_mux_pin: assert property (sc1_wr && reg_wdata[4:3] == 2'b00
		|-> ##2 mux_sel.pin == (8'h01 << $past(reg_wdata[2:0], 2)))
		else $error("pin routing wrong");
	chk_mux_power: assert property (sc1_wr |-> ##2 mux_sel.powered == ($past(reg_wdata[4:0], 2) != SAR_SEL_OFF))
		else $error("power routing wrong");
	chk_start_active: assert property (sc1_go && conv_clock_on |-> ##2 conv_active)
		else $error("write did not start conversion");
	chk_off_idle: assert property (sc1_wr && reg_wdata[4:0] == SAR_SEL_OFF |-> ##2 !conv_active [*8])
		else $error("conversion after off code");
	chk_done_early: assert property (sc1_go |-> ##2 irq_quiet)
		else $error("completion too early");
	chk_flag_clear: assert property (sc1_wr |-> ##2 !conv_irq)
		else $error("flag not cleared by write");
	chk_single_idle: assert property ($fell(conv_active) && !cont_r && !$past(reg_wr, 2)
		|=> !conv_active [*2])
		else $error("single conversion restarted");
	chk_irq_enable: assert property ($rose(conv_irq) |-> $past(aien_r))
		else $error("interrupt while disabled");
endmodule : sar_ctrl_checker
`default_nettype wire
